/* tc8_pkg.sv */
// Package of constants for the 8-bit timer compare unit
package tc8_pkg;

	// ==========================================
	// Register map (byte addresses)
	localparam logic [4:0] TC8_OFS_CTRL   = 5'h00; // Timer control register
	localparam logic [4:0] TC8_OFS_COUNT  = 5'h04; // Counter value
	localparam logic [4:0] TC8_OFS_CMP    = 5'h08; // Compare value
	localparam logic [4:0] TC8_OFS_FLAGS  = 5'h0C; // Interrupt flags
	localparam logic [4:0] TC8_OFS_MASKS  = 5'h10; // Interrupt masks
	localparam int         TC8_ADDR_W     = 5;     // Decoded address bits

	// ==========================================
	// Control register fields
	localparam int TC8_CS_LSB    = 0; // Clock select field, 3 bits
	localparam int TC8_WGM_LSB   = 3; // Waveform mode field, 2 bits
	localparam int TC8_COM_LSB   = 5; // Compare output mode, 2 bits
	localparam int TC8_FORCE_BIT = 7; // Force compare strobe, reads zero
	localparam int TC8_ASYNC_BIT = 8; // Asynchronous clock select
	localparam int TC8_OVF_BIT   = 0; // Overflow flag / enable
	localparam int TC8_CMP_BIT   = 1; // Compare flag / enable

	// ==========================================
	// Counter values
	localparam logic [7:0] TC8_BOTTOM = 8'h00; // Bottom of count
	localparam logic [7:0] TC8_MAX    = 8'hFF; // Maximum of count

	// ==========================================
	// Codes
	localparam logic [2:0] TC8_CS_NONE  = 3'h0; // No clock source
	localparam logic [1:0] TC8_WGM_NORM = 2'h0; // Normal up-count
	localparam logic [1:0] TC8_WGM_PC   = 2'h1; // Phase-correct PWM
	localparam logic [1:0] TC8_WGM_CTC  = 2'h2; // Clear on compare
	localparam logic [1:0] TC8_WGM_FAST = 2'h3; // Fast PWM
	localparam logic [1:0] TC8_COM_OFF  = 2'h0; // No output action
	localparam logic [1:0] TC8_COM_TGL  = 2'h1; // Toggle
	localparam logic [1:0] TC8_COM_CLR  = 2'h2; // Clear / non-inverted
	localparam logic [1:0] TC8_COM_SET  = 2'h3; // Set / inverted
	localparam logic [1:0] TC8_RESP_OK  = 2'h0; // AXI OKAY
	localparam logic [1:0] TC8_RESP_ERR = 2'h2; // AXI SLVERR

	// ==========================================
	// Prescaler divide masks (divider minus one), per clock select code
	localparam int TC8_PRE_W = 10; // Prescaler width
	localparam logic [9:0] TC8_DIV1    = 10'h000;
	localparam logic [9:0] TC8_DIV8    = 10'h007;
	localparam logic [9:0] TC8_DIV32   = 10'h01F;
	localparam logic [9:0] TC8_DIV64   = 10'h03F;
	localparam logic [9:0] TC8_DIV128  = 10'h07F;
	localparam logic [9:0] TC8_DIV256  = 10'h0FF;
	localparam logic [9:0] TC8_DIV1024 = 10'h3FF;

endpackage

/* tc8_tick_if.sv */
// Interface carrying clock selection and the timer tick between modules
interface tc8_tick_if;
	logic [2:0] clock_select_field; // Selected source, zero stops
	logic       async_clock_select; // One selects oscillator pin
	logic       timer_tick_clock;   // One-cycle timer tick enable

	modport src (
		input  clock_select_field,
		input  async_clock_select,
		output timer_tick_clock
	);
	modport use_tick (
		output clock_select_field,
		output async_clock_select,
		input  timer_tick_clock
	);
endinterface

/* tc8_tick.sv */
// Clock source select and prescaler producing the timer tick enable
module tc8_tick
	import tc8_pkg::*;
#(
	parameter int PRE_W = TC8_PRE_W
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic osc_pin_in,
	tc8_tick_if.src   tk
);

	// ==========================================
	// Elaboration check
	if (PRE_W != TC8_PRE_W) begin : g_chk
		$error("tc8_tick: PRE_W must be 10");
	end

	typedef struct packed {
		logic [9:0] pres;    // Prescaler count of source pulses
		logic       osc_s1;  // Synchroniser first stage
		logic       osc_s2;  // Synchroniser second stage
		logic       osc_d;   // Delayed copy for edge detect
		logic       tick;    // Registered timer tick
	} tc8_tick_st_t;

	tc8_tick_st_t st_r;  // State
	tc8_tick_st_t st_nxt; // Next state

	// Divide mask for a clock select code
	function automatic logic [9:0] div_mask(input logic [2:0] cs);
		case (cs)
			3'h1:    div_mask = TC8_DIV1;
			3'h2:    div_mask = TC8_DIV8;
			3'h3:    div_mask = TC8_DIV32;
			3'h4:    div_mask = TC8_DIV64;
			3'h5:    div_mask = TC8_DIV128;
			3'h6:    div_mask = TC8_DIV256;
			default: div_mask = TC8_DIV1024;
		endcase
	endfunction

	// ==========================================
	// Next state
	always_comb begin
		logic src_pulse;
		logic [9:0] m;
		src_pulse = 1'b0;
		m = div_mask(tk.clock_select_field);
		st_nxt = st_r;
		st_nxt.osc_s1 = osc_pin_in;
		st_nxt.osc_s2 = st_r.osc_s1;
		st_nxt.osc_d = st_r.osc_s2;
		// Source: every I/O clock, or oscillator rising edge
		if (tk.async_clock_select) begin
			src_pulse = st_r.osc_s2 & ~st_r.osc_d;
		end else begin
			src_pulse = 1'b1;
		end
		st_nxt.tick = 1'b0;
		if (tk.clock_select_field == TC8_CS_NONE) begin
			st_nxt.pres = '0;
		end else if (src_pulse) begin
			st_nxt.pres = st_r.pres + 10'h001;
			st_nxt.tick = ((st_r.pres & m) == m);
		end
	end

	// ==========================================
	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tk.timer_tick_clock = st_r.tick;

endmodule

/* tc8_timer.sv */
// Top of the 8-bit timer with compare unit and AXI4-Lite registers
// Overview of operation
// - 8-bit counter, bottom and max indications
// - Top is max or compare value
// - Async select takes oscillator pin clock
// - Clock select zero stops the counter
// - CPU counter write beats count or clear
// - Tick clears, increments or decrements per mode
// - Overflow flag set per mode, interrupt source
// - Match sets compare flag on next tick
// - Enabled flag requests interrupt; ack or W1C clears
// - Shared flag and mask registers
// - Compare double buffered only in PWM modes
// - CPU reaches buffer or active compare
// - Force strobe acts like match in non-PWM modes, no flag
// - Counter write blocks match next tick
// - Output state kept across mode changes
// - Output mode bits apply at once
// - Nonzero output mode overrides port pin value
// - Mode codes zero to three
// - Output mode zero takes no action
module tc8_timer
	import tc8_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        osc_pin_in,
	input  wire logic        ovf_irq_ack,
	input  wire logic        cmp_irq_ack,
	output logic             ovf_irq_req,
	output logic             cmp_irq_req,
	input  wire logic        port_out_value,
	input  wire logic        compare_pin_direction,
	output logic             compare_pin_out,
	output logic             compare_pin_oe,
	output logic             count_at_bottom,
	output logic             count_at_max
);

	// ==========================================
	// State
	typedef struct packed {
		logic [4:0]  awaddr;        // Held write address
		logic        aw_got;        // Write address taken
		logic [31:0] wdata;         // Held write data
		logic [3:0]  wstrb;         // Held byte strobes
		logic        w_got;         // Write data taken
		logic        bvalid;        // Write response pending
		logic [1:0]  bresp;         // Write response code
		logic        rvalid;        // Read data pending
		logic [31:0] rdata;         // Read data
		logic [1:0]  rresp;         // Read response code
		logic [2:0]  cs;            // Clock select field
		logic [1:0]  wgm;           // Waveform mode field
		logic [1:0]  com;           // Compare output mode
		logic        async_sel;     // Async clock select
		logic [7:0]  cnt;           // Counter value
		logic [7:0]  ocr;           // Active compare value
		logic [7:0]  ocr_buf;       // Compare buffer
		logic        down;          // Counting down
		logic        oc;            // Compare output state
		logic        ovf;           // Overflow flag
		logic        cmpf;          // Compare flag
		logic        ovf_en;        // Overflow interrupt enable
		logic        cmp_en;        // Compare interrupt enable
		logic        block;         // Match blocked at next tick
		logic        pin;           // Registered pin value
	} tc8_st_t;

	tc8_st_t st_r;   // State register
	tc8_st_t st_nxt; // Next state

	tc8_tick_if tk (); // Tick link to the prescaler

	// ==========================================
	// Prescaler and clock source
	tc8_tick #(
		.PRE_W (TC8_PRE_W)
	) u_tick (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.osc_pin_in (osc_pin_in),
		.tk         (tk)
	);

	assign tk.clock_select_field = st_r.cs;
	assign tk.async_clock_select = st_r.async_sel;

	// ==========================================
	// Helper functions
	// Address decode: 0..4 valid, 7 unmapped
	function automatic logic [2:0] reg_sel(input logic [4:0] a);
		case (a)
			TC8_OFS_CTRL:  reg_sel = 3'h0;
			TC8_OFS_COUNT: reg_sel = 3'h1;
			TC8_OFS_CMP:   reg_sel = 3'h2;
			TC8_OFS_FLAGS: reg_sel = 3'h3;
			TC8_OFS_MASKS: reg_sel = 3'h4;
			default:       reg_sel = 3'h7;
		endcase
	endfunction

	// Non-PWM match action on the output state
	function automatic logic np_action(input logic [1:0] com, input logic oc);
		case (com)
			TC8_COM_TGL: np_action = ~oc;
			TC8_COM_CLR: np_action = 1'b0;
			TC8_COM_SET: np_action = 1'b1;
			default:     np_action = oc;
		endcase
	endfunction

	// PWM modes use the compare buffer
	function automatic logic is_pwm(input logic [1:0] wgm);
		is_pwm = (wgm == TC8_WGM_PC) || (wgm == TC8_WGM_FAST);
	endfunction

	// ==========================================
	// Next state
	always_comb begin
		logic       tick;
		logic       match;
		logic       m_ev;
		logic       ovf_set;
		logic       cmp_set;
		logic [2:0] wsel;
		logic [7:0] top;
		logic       pwm;
		tick = tk.timer_tick_clock;
		pwm = is_pwm(st_r.wgm);
		ovf_set = 1'b0;
		cmp_set = 1'b0;
		wsel = reg_sel(st_r.awaddr);
		st_nxt = st_r;

		// Top select
		top = (st_r.wgm == TC8_WGM_CTC) ? st_r.ocr : TC8_MAX;
		match = (st_r.cnt == st_r.ocr);
		m_ev = tick && match && !st_r.block;

		// Counter unit, runs on the timer tick
		if (tick) begin
			st_nxt.block = 1'b0;
			case (st_r.wgm)
				TC8_WGM_NORM: begin
					st_nxt.cnt = st_r.cnt + 8'h01;
					ovf_set = (st_r.cnt == TC8_MAX);
				end
				TC8_WGM_CTC: begin
					st_nxt.cnt = (st_r.cnt == top) ? TC8_BOTTOM : st_r.cnt + 8'h01;
					ovf_set = (st_r.cnt == TC8_MAX);
				end
				TC8_WGM_FAST: begin
					st_nxt.cnt = st_r.cnt + 8'h01;
					ovf_set = (st_r.cnt == TC8_MAX);
					if (st_r.cnt == top) begin
						st_nxt.ocr = st_r.ocr_buf;
						if (st_r.com == TC8_COM_CLR) begin
							st_nxt.oc = 1'b1;
						end else if (st_r.com == TC8_COM_SET) begin
							st_nxt.oc = 1'b0;
						end
					end
				end
				TC8_WGM_PC: begin
					if (st_r.down) begin
						st_nxt.cnt = st_r.cnt - 8'h01;
						st_nxt.down = (st_r.cnt != 8'h01);
						ovf_set = (st_r.cnt == 8'h01);
						// Top is first seen on the down step: load buffer here
						if (st_r.cnt == top) begin
							st_nxt.ocr = st_r.ocr_buf;
						end
					end else begin
						st_nxt.cnt = st_r.cnt + 8'h01;
						st_nxt.down = (st_r.cnt == 8'hFE);
						if (st_r.cnt == top) begin
							st_nxt.cnt = st_r.cnt - 8'h01;
							st_nxt.down = 1'b1;
							st_nxt.ocr = st_r.ocr_buf;
						end
					end
				end
				default: begin
					st_nxt.cnt = st_r.cnt;
				end
			endcase
			// Leave down-count state when not phase correct
			if (st_r.wgm != TC8_WGM_PC) begin
				st_nxt.down = 1'b0;
			end
		end

		// Compare match actions on the output state
		if (m_ev) begin
			cmp_set = 1'b1;
			case (st_r.wgm)
				TC8_WGM_FAST: begin
					if (st_r.com == TC8_COM_TGL) begin
						st_nxt.oc = ~st_r.oc;
					end else if (st_r.com == TC8_COM_CLR) begin
						st_nxt.oc = 1'b0;
					end else if (st_r.com == TC8_COM_SET) begin
						st_nxt.oc = 1'b1;
					end
				end
				TC8_WGM_PC: begin
					if (st_r.com == TC8_COM_CLR) begin
						st_nxt.oc = st_r.down;
					end else if (st_r.com == TC8_COM_SET) begin
						st_nxt.oc = ~st_r.down;
					end
				end
				default: begin
					st_nxt.oc = np_action(st_r.com, st_r.oc);
				end
			endcase
		end

		// Interrupt flag clears by ack, then sets win
		if (ovf_irq_ack) begin
			st_nxt.ovf = 1'b0;
		end
		if (cmp_irq_ack) begin
			st_nxt.cmpf = 1'b0;
		end

		// AXI write channel capture
		if (s_axi_awvalid && s_axi_awready) begin
			st_nxt.awaddr = s_axi_awaddr[TC8_ADDR_W-1:0];
			st_nxt.aw_got = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
			st_nxt.w_got = 1'b1;
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end

		// Register write once address and data are both held
		if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = (wsel == 3'h7) ? TC8_RESP_ERR : TC8_RESP_OK;
			if (st_r.wstrb[0]) begin
				case (wsel)
					3'h0: begin
						st_nxt.cs = st_r.wdata[TC8_CS_LSB +: 3];
						st_nxt.wgm = st_r.wdata[TC8_WGM_LSB +: 2];
						st_nxt.com = st_r.wdata[TC8_COM_LSB +: 2];
						if (st_r.wdata[TC8_FORCE_BIT] && !is_pwm(st_r.wdata[TC8_WGM_LSB +: 2])) begin
							st_nxt.oc = np_action(st_r.wdata[TC8_COM_LSB +: 2], st_r.oc);
						end
					end
					3'h1: begin
						st_nxt.cnt = st_r.wdata[7:0];
						st_nxt.block = 1'b1;
					end
					3'h2: begin
						st_nxt.ocr_buf = st_r.wdata[7:0];
						if (!pwm) begin
							st_nxt.ocr = st_r.wdata[7:0];
						end
					end
					3'h3: begin
						if (st_r.wdata[TC8_OVF_BIT]) begin
							st_nxt.ovf = 1'b0;
						end
						if (st_r.wdata[TC8_CMP_BIT]) begin
							st_nxt.cmpf = 1'b0;
						end
					end
					3'h4: begin
						st_nxt.ovf_en = st_r.wdata[TC8_OVF_BIT];
						st_nxt.cmp_en = st_r.wdata[TC8_CMP_BIT];
					end
					default: begin
						st_nxt.block = st_r.block;
					end
				endcase
			end
			if (st_r.wstrb[1] && wsel == 3'h0) begin
				st_nxt.async_sel = st_r.wdata[TC8_ASYNC_BIT];
			end
		end

		// Hardware sets win over any clear
		if (ovf_set) begin
			st_nxt.ovf = 1'b1;
		end
		if (cmp_set) begin
			st_nxt.cmpf = 1'b1;
		end

		// AXI read channel
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = TC8_RESP_OK;
			st_nxt.rdata = '0;
			case (reg_sel(s_axi_araddr[TC8_ADDR_W-1:0]))
				3'h0: begin
					st_nxt.rdata[TC8_CS_LSB +: 3] = st_r.cs;
					st_nxt.rdata[TC8_WGM_LSB +: 2] = st_r.wgm;
					st_nxt.rdata[TC8_COM_LSB +: 2] = st_r.com;
					st_nxt.rdata[TC8_ASYNC_BIT] = st_r.async_sel;
				end
				3'h1: st_nxt.rdata[7:0] = st_r.cnt;
				3'h2: st_nxt.rdata[7:0] = pwm ? st_r.ocr_buf : st_r.ocr;
				3'h3: begin
					st_nxt.rdata[TC8_OVF_BIT] = st_r.ovf;
					st_nxt.rdata[TC8_CMP_BIT] = st_r.cmpf;
				end
				3'h4: begin
					st_nxt.rdata[TC8_OVF_BIT] = st_r.ovf_en;
					st_nxt.rdata[TC8_CMP_BIT] = st_r.cmp_en;
				end
				default: st_nxt.rresp = TC8_RESP_ERR;
			endcase
		end

		// Pin value: waveform output overrides port value
		st_nxt.pin = (st_nxt.com != TC8_COM_OFF) ? st_nxt.oc : port_out_value;
	end

	// ==========================================
	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================
	// Outputs
	assign s_axi_awready   = !st_r.aw_got && !st_r.bvalid;
	assign s_axi_wready    = !st_r.w_got && !st_r.bvalid;
	assign s_axi_bvalid    = st_r.bvalid;
	assign s_axi_bresp     = st_r.bresp;
	assign s_axi_arready   = !st_r.rvalid;
	assign s_axi_rvalid    = st_r.rvalid;
	assign s_axi_rdata     = st_r.rdata;
	assign s_axi_rresp     = st_r.rresp;
	assign ovf_irq_req     = st_r.ovf && st_r.ovf_en;
	assign cmp_irq_req     = st_r.cmpf && st_r.cmp_en;
	assign compare_pin_out = st_r.pin;
	assign compare_pin_oe  = compare_pin_direction;
	assign count_at_bottom = (st_r.cnt == TC8_BOTTOM);
	assign count_at_max    = (st_r.cnt == TC8_MAX);

endmodule

/* tc8_timer_properties.sv */
// Port-level assertions for the 8-bit timer compare unit
module tc8_timer_properties
	import tc8_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        cmp_irq_ack,
	input wire logic        cmp_irq_req,
	input wire logic        compare_pin_direction,
	input wire logic        compare_pin_oe,
	input wire logic        count_at_bottom,
	input wire logic        count_at_max
);
	// ==========================================
	// Common clock and reset
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ==========================================
	// Pin, counter and compare interrupt indications
	a_oe_tracks_dir: assert property (
		compare_pin_oe == compare_pin_direction) else $error("pin enable not from direction");
	a_bottom_max_excl: assert property (
		!(count_at_bottom && count_at_max)) else $error("bottom and max both high");
	a_reset_at_bottom: assert property (
		$rose(aresetn) |-> count_at_bottom) else $error("counter not at bottom after reset");
	a_cmp_req_drop: assert property (
		$fell(cmp_irq_req) |-> $past(cmp_irq_ack) || s_axi_bvalid || !$past(aresetn))
		else $error("compare request dropped without cause");

	// ==========================================
	// Register bus handshakes
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	a_b_stands: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write answer withdrawn");
	a_r_stands: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed");
	a_refuse_write: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
	a_refuse_read: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");

	// Main scenarios seen
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_cmp_irq: cover property ($rose(cmp_irq_req));
endmodule

bind tc8_timer tc8_timer_properties i_props (.*);

/* tc8_cpu_model.sv */
// Interrupt acknowledge model of the CPU core
module tc8_cpu_model (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ack_en,
	input  wire logic cmp_irq_req,
	input  wire logic ovf_irq_req,
	output logic      cmp_irq_ack,
	output logic      ovf_irq_ack
);
	// One-cycle acknowledge when an enabled request is seen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_irq_ack <= 1'b0;
			ovf_irq_ack <= 1'b0;
		end else begin
			cmp_irq_ack <= ack_en && cmp_irq_req && !cmp_irq_ack;
			ovf_irq_ack <= ack_en && ovf_irq_req && !ovf_irq_ack;
		end
	end
endmodule

/* testbench.sv */
// Self-checking bench of the 8-bit timer compare unit
module testbench
	import tc8_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// Stimulus and observed signals
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        osc = 1'b0, port_v = 1'b0, dir = 1'b0, ack_en = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, cmp_ack, ovf_ack;
	logic        cmp_req, ovf_req, pin, oe, bot, mx;
	logic [1:0]  bresp, rresp;
	logic [33:0] exp_q[$];              // Expected {resp, data} per read
	int          bad_count = 0, num_checks = 0;

	always #50 aclk = ~aclk;             // 10 MHz

	tc8_timer i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.osc_pin_in(osc), .ovf_irq_ack(ovf_ack), .cmp_irq_ack(cmp_ack),
		.ovf_irq_req(ovf_req), .cmp_irq_req(cmp_req), .port_out_value(port_v),
		.compare_pin_direction(dir), .compare_pin_out(pin), .compare_pin_oe(oe),
		.count_at_bottom(bot), .count_at_max(mx));

	tc8_cpu_model i_cpu (.aclk(aclk), .aresetn(aresetn), .ack_en(ack_en),
		.cmp_irq_req(cmp_req), .ovf_irq_req(ovf_req),
		.cmp_irq_ack(cmp_ack), .ovf_irq_ack(ovf_ack));

	// ==========================================
	// Helpers
	function automatic logic [31:0] ad(logic [4:0] o);
		return {27'h0, o};
	endfunction
	function automatic logic [33:0] ok(logic [7:0] x);
		return {TC8_RESP_OK, 24'h0, x};
	endfunction
	task automatic final_report();
		if (bad_count == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tmo();
		bad_count++;
		$display("MISMATCH at %0t: wait ran out", $time);
		final_report();
	endtask
	// Bus write, address and data offered together
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		int n;
		logic aw, w, b;
		n = 0;
		b = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b) begin
			@(negedge aclk);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid;
			if (b) chk({32'h0, bresp}, {32'h0, TC8_RESP_OK});
			@(posedge aclk);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (++n > 50) tmo();
		end
		bready <= 1'b0;
	endtask
	// Bus read, expectation queued for the monitor
	task automatic rd(input logic [31:0] a, input logic [33:0] e);
		int n;
		logic ar, r;
		n = 0;
		r = 1'b0;
		exp_q.push_back(e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r) begin
			@(negedge aclk);
			ar = arvalid && arready;
			r = rvalid;
			@(posedge aclk);
			if (ar) arvalid <= 1'b0;
			if (++n > 50) tmo();
		end
		rready <= 1'b0;
	endtask
	task automatic pin_is(input logic e);
		repeat (3) @(negedge aclk);
		chk({33'h0, pin}, {33'h0, e});
	endtask
	// Cycles until the pin changes level
	task automatic wait_chg(output int n);
		logic p;
		p = pin;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
			if (n > 100) tmo();
		end while (pin === p);
	endtask

	// Monitor: oldest note against each read answer
	always @(negedge aclk) begin
		if (aresetn && rvalid && rready) begin
			if (exp_q.size() == 0) tmo();
			else chk({rresp, rdata}, exp_q.pop_front());
		end
	end

	// Hang guard
	initial begin
		repeat (100000) @(posedge aclk);
		tmo();
	end

	// ==========================================
	// Main sequence
	initial begin
		logic [7:0] v;
		logic [1:0] com_t [4];
		int n;
		com_t = '{TC8_COM_SET, TC8_COM_CLR, TC8_COM_TGL, TC8_COM_TGL};
		void'($urandom(32'h1FE2));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 5; i++) rd(32'(i * 4), 34'h0);
		rd(32'h14, {TC8_RESP_ERR, 32'h0});
		chk({33'h0, bot}, 34'h1);
		repeat (4) begin
			v = 8'($urandom);
			wr(ad(TC8_OFS_COUNT), {24'h0, v});
			repeat (20) @(posedge aclk);
			rd(ad(TC8_OFS_COUNT), ok(v));
		end
		wr(ad(TC8_OFS_COUNT), 32'hFF);
		pin_is(1'b0);
		chk({33'h0, mx}, 34'h1);
		// Counter write equal to compare, then a full lap
		wr(ad(TC8_OFS_CMP), 32'h10);
		wr(ad(TC8_OFS_COUNT), 32'h10);
		wr(ad(TC8_OFS_CTRL), 32'h01);
		repeat (5) @(posedge aclk);
		rd(ad(TC8_OFS_FLAGS), ok(8'h00));
		repeat (300) @(posedge aclk);
		rd(ad(TC8_OFS_FLAGS), ok(8'h03));
		wr(ad(TC8_OFS_MASKS), 32'h01);
		@(negedge aclk);
		chk({33'h0, ovf_req}, 34'h1);
		wr(ad(TC8_OFS_FLAGS), 32'h03);
		rd(ad(TC8_OFS_FLAGS), ok(8'h00));
		// Oscillator pin as tick source
		wr(ad(TC8_OFS_CTRL), 32'h00);
		wr(ad(TC8_OFS_COUNT), 32'h00);
		wr(ad(TC8_OFS_CTRL), 32'h101);
		repeat (10) begin
			repeat (3) @(posedge aclk);
			osc <= 1'b1;
			repeat (3) @(posedge aclk);
			osc <= 1'b0;
		end
		repeat (8) @(posedge aclk);
		wr(ad(TC8_OFS_CTRL), 32'h00);
		rd(ad(TC8_OFS_COUNT), ok(8'h0A));
		// Forced compare in normal mode, stopped
		for (int i = 0; i < 4; i++) begin
			wr(ad(TC8_OFS_CTRL), {24'h0, 1'b1, com_t[i], 5'h0});
			pin_is(1'(4'h5 >> i));
		end
		rd(ad(TC8_OFS_FLAGS), ok(8'h00));
		rd(ad(TC8_OFS_COUNT), ok(8'h0A));
		@(posedge aclk);
		dir <= 1'b1;
		wr(ad(TC8_OFS_CTRL), {24'h0, 1'b0, TC8_COM_SET, TC8_WGM_FAST, 3'h0});
		pin_is(1'b0);
		wr(ad(TC8_OFS_CTRL), {24'h0, 1'b1, TC8_COM_SET, TC8_WGM_FAST, 3'h0});
		pin_is(1'b0);
		wr(ad(TC8_OFS_CMP), 32'h40);
		rd(ad(TC8_OFS_CMP), ok(8'h40));
		// Clear on compare with toggling output
		wr(ad(TC8_OFS_CTRL), 32'h30);
		wr(ad(TC8_OFS_CMP), 32'h05);
		wr(ad(TC8_OFS_COUNT), 32'h00);
		wr(ad(TC8_OFS_CTRL), 32'h31);
		@(negedge aclk);
		wait_chg(n);
		wait_chg(n);
		chk(34'(n), 34'h6);
		// Compare interrupt held, then acknowledged
		wr(ad(TC8_OFS_MASKS), 32'h02);
		wr(ad(TC8_OFS_CTRL), 32'h30);
		repeat (10) @(negedge aclk);
		chk({33'h0, cmp_req}, 34'h1);
		@(posedge aclk);
		ack_en <= 1'b1;
		repeat (3) @(negedge aclk);
		chk({33'h0, cmp_req}, 34'h0);
		// Output mode zero hands the pin back to the port
		wr(ad(TC8_OFS_CTRL), 32'h10);
		v = 8'($urandom);
		@(posedge aclk);
		port_v <= v[0];
		pin_is(v[0]);
		@(posedge aclk);
		port_v <= ~v[0];
		pin_is(~v[0]);
		// Phase-correct PWM: low time spans old match up, new match down
		wr(ad(TC8_OFS_CTRL), 32'hF0);
		pin_is(1'b1);
		wr(ad(TC8_OFS_CMP), 32'hFA);
		wr(ad(TC8_OFS_COUNT), 32'hF0);
		wr(ad(TC8_OFS_CTRL), 32'h48);
		wr(ad(TC8_OFS_CMP), 32'hFC);
		wr(ad(TC8_OFS_CTRL), 32'h49);
		@(negedge aclk);
		wait_chg(n);
		wait_chg(n);
		chk(34'(n), 34'h8);
		final_report();
	end
endmodule
